//--- verilog/ecs_pkg.sv
// constants for the ecc status and control register bank
`default_nettype none
package ecs_pkg;
	// data word geometry: PARTS 64-bit parts per word
	localparam int PARTS = 2;
	localparam int DATA_W = 64 * PARTS;
	localparam int SUB_W = 32;
	localparam int SUB_DEPTH = 2 * PARTS;
	localparam int SYND_W = 8;
	localparam int ST_W = 5;
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_CMD = 6'h00;
	localparam logic [5:0] IDX_STHR = 6'h01;
	localparam logic [5:0] IDX_DTHR = 6'h02;
	localparam logic [5:0] IDX_SCNT = 6'h03;
	localparam logic [5:0] IDX_DCNT = 6'h04;
	localparam logic [5:0] IDX_SADDR = 6'h05;
	localparam logic [5:0] IDX_DADDR = 6'h06;
	localparam logic [5:0] IDX_SDATA = 6'h07;
	localparam logic [5:0] IDX_SSYND = 6'h08;
	localparam logic [5:0] IDX_DDATA = 6'h09;
	localparam logic [5:0] IDX_STATUS = 6'h0a;
	localparam logic [5:0] IDX_MASK = 6'h0b;
	localparam logic [5:0] IDX_SLOC = 6'h0c;
	localparam logic [5:0] IDX_DLOC = 6'h0d;
	// reset values
	localparam logic [31:0] CMD_RST = 32'h0000000f;
	localparam logic [31:0] THR_RST = 32'h00000001;
	localparam logic [4:0] MASK_RST = 5'h01;
	// command word bit positions
	localparam int BIT_CNT_SERR = 0;
	localparam int BIT_CORR = 1;
	localparam int BIT_DET_DERR = 2;
	localparam int BIT_CLR_ALL = 4;
	localparam int BIT_CLR_RD = 7;
	localparam int BIT_CORRUPT = 8;
	localparam int BIT_CORRUPT_DBL = 9;
	localparam int BIT_FIRST = 10;
	localparam int BIT_CLR_IRQ = 11;
	// action bits that never stay set in the command word
	localparam logic [31:0] CMD_ACTION = 32'h00000810;
	// interrupt status bit positions
	localparam int ST_SERR = 0;
	localparam int ST_DERR = 1;
	localparam int ST_SMAX = 2;
	localparam int ST_DMAX = 3;
	localparam int ST_RMW = 4;
endpackage : ecs_pkg
`default_nettype wire

//--- verilog/ecs_capture_fifo.sv
// capture fifo: parallel load of a whole word, popped one entry at a time
`default_nettype none
module ecs_capture_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 4,
	parameter int PW = 2,
	parameter int LW = 3
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic [W*DEPTH-1:0] load_data_i,
	input wire logic pop_i,
	input wire logic clr_i,
	output logic [W-1:0] head_o,
	output logic [PW-1:0] ptr_o,
	output logic [LW-1:0] level_o
);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] rd_ptr;
	logic [LW-1:0] level;

	// storage, entry 0 is the low part of the word
	always_ff @(posedge clk_i) begin
		if (load_i) begin
			for (int k = 0; k < DEPTH; k++) begin
				mem[k] <= load_data_i[k*W +: W];
			end
		end
	end

	// pointer and fill level; a new load wins over clear and pop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_ptr <= '0;
			level <= '0;
		end else if (load_i) begin
			rd_ptr <= '0;
			level <= LW'(DEPTH);
		end else if (clr_i) begin
			rd_ptr <= '0;
			level <= '0;
		end else if (pop_i && level != '0) begin
			rd_ptr <= rd_ptr + 1'b1;
			level <= level - 1'b1;
		end
	end

	// empty fifo reads as zero
	assign head_o = (level != '0) ? mem[rd_ptr] : '0;
	assign ptr_o = rd_ptr;
	assign level_o = level;
endmodule : ecs_capture_fifo
`default_nettype wire

//--- verilog/ecs_err_counter.sv
// saturating error counter with threshold crossing detect
`default_nettype none
module ecs_err_counter (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic inc_i,
	input wire logic clr_i,
	input wire logic [31:0] thr_i,
	output logic [31:0] count_o,
	output logic cross_o
);
	logic [31:0] count;
	logic [31:0] base;

	// clear and increment in one cycle give a count of one
	assign base = clr_i ? 32'h00000000 : count;
	// crossing: the count steps from the threshold to above it
	assign cross_o = inc_i && (base == thr_i) && (base != 32'hffffffff);
	assign count_o = count;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= 32'h00000000;
		end else if (inc_i && base != 32'hffffffff) begin
			count <= base + 32'h00000001;
		end else begin
			count <= base;
		end
	end
endmodule : ecs_err_counter
`default_nettype wire

//--- verilog/ecs_ecc_regs.sv
// ecc control and status register bank on a classic wishbone slave
//
// Behaviour
// RQ1: command word at 00, resets to 0000000f.
// RQ2: error counters count; crossing threshold raises interrupt.
// RQ3: counts readable at 03 and 04, reset zero.
// RQ4: last single error address at 05, clearable.
// RQ5: last double error address at 06, clearable.
// RQ6: command bit 10 keeps first address instead.
// RQ7: single error data fifo at 07, low first.
// RQ8: clear command empties the error data fifos.
// RQ9: single error syndromes, one per part, at 08.
// RQ10: syndrome follows the part of shown data.
// RQ11: double error data fifo at 09, low first.
// RQ12: five-bit status at 0a, write one clears.
// RQ13: write-only mask at 0b, resets to 01.
// RQ14: single error part flags at 0c, w1c.
// RQ15: double error part flags at 0d, w1c.
// RQ16: bits 0..2 enable count, correct, detect.
// RQ17: bit 8 corrupts encoding, bit 9 picks kind.
// RQ18: bit 4 clears; bit 7 clears counters on read.
// RQ19: command bit 11 clears pending interrupt status.
// RQ20: interrupt out when unmasked status bit set.
`default_nettype none
module ecs_ecc_regs (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic SERR_I,
	input wire logic DERR_I,
	input wire logic RMW_DERR_I,
	input wire logic [31:0] ERR_ADDR_I,
	input wire logic [ecs_pkg::DATA_W-1:0] ERR_DATA_I,
	input wire logic [ecs_pkg::PARTS*ecs_pkg::SYND_W-1:0] ERR_SYND_I,
	input wire logic [ecs_pkg::PARTS-1:0] ERR_PART_I,
	output logic COUNT_SERR_EN_O,
	output logic CORRECT_EN_O,
	output logic DETECT_DERR_EN_O,
	output logic CORRUPT_EN_O,
	output logic CORRUPT_DOUBLE_O,
	output logic IRQ_O
);
	import ecs_pkg::*;

	localparam int DPW = $clog2(SUB_DEPTH);
	localparam int DLW = $clog2(SUB_DEPTH + 1);
	localparam int SPW = (PARTS > 1) ? $clog2(PARTS) : 1;
	localparam int SLW = $clog2(PARTS + 1);

	logic ack;
	logic req;
	logic wr;
	logic rd;
	logic [5:0] idx;
	logic [31:0] bmask;
	logic [31:0] wdat;
	logic [31:0] rdata;
	logic [31:0] cmd;
	logic [31:0] sthr;
	logic [31:0] dthr;
	logic [4:0] mask;
	logic [4:0] status;
	logic [4:0] st_set;
	logic [4:0] st_clr;
	logic [PARTS-1:0] sloc;
	logic [PARTS-1:0] dloc;
	logic [31:0] saddr;
	logic [31:0] daddr;
	logic s_have;
	logic d_have;
	logic clr_all;
	logic clr_irq;
	logic s_inc;
	logic d_ev;
	logic s_cnt_clr;
	logic d_cnt_clr;
	logic [31:0] scount;
	logic [31:0] dcount;
	logic s_cross;
	logic d_cross;
	logic sdata_pop;
	logic ssynd_pop;
	logic ddata_pop;
	logic [31:0] sdata_head;
	logic [31:0] ddata_head;
	logic [SYND_W-1:0] ssynd_head;
	logic [DPW-1:0] sdata_ptr;
	logic [DLW-1:0] sdata_level;
	logic [SPW-1:0] ssynd_ptr;
	logic [SLW-1:0] ssynd_level;

	// bus request decode, one access per cycle of ack
	assign req = CYC_I && STB_I && !ack;
	assign wr = req && WE_I;
	assign rd = req && !WE_I;
	assign idx = ADR_I[7:2];
	assign bmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
	assign wdat = DAT_I & bmask;

	// command actions, taken only on the write edge
	assign clr_all = wr && idx == IDX_CMD && wdat[BIT_CLR_ALL]; // [RQ18]
	assign clr_irq = wr && idx == IDX_CMD && wdat[BIT_CLR_IRQ]; // [RQ19]

	// error events as qualified by the command word
	assign s_inc = SERR_I && cmd[BIT_CNT_SERR]; // [RQ16]
	assign d_ev = DERR_I && cmd[BIT_DET_DERR]; // [RQ16]

	// counter clears: clear command, or read with clear-on-read set
	assign s_cnt_clr = clr_all || (rd && idx == IDX_SCNT && cmd[BIT_CLR_RD]); // [RQ18]
	assign d_cnt_clr = clr_all || (rd && idx == IDX_DCNT && cmd[BIT_CLR_RD]); // [RQ18]

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end
	assign ACK_O = ack;

	// command word; action bits do not stay set
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cmd <= CMD_RST; // [RQ1]
		end else if (wr && idx == IDX_CMD) begin
			cmd <= ((cmd & ~bmask) | wdat) & ~CMD_ACTION; // [RQ1]
		end
	end

	// enables and test corruption controls toward the codec
	assign COUNT_SERR_EN_O = cmd[BIT_CNT_SERR]; // [RQ16]
	assign CORRECT_EN_O = cmd[BIT_CORR]; // [RQ16]
	assign DETECT_DERR_EN_O = cmd[BIT_DET_DERR]; // [RQ16]
	assign CORRUPT_EN_O = cmd[BIT_CORRUPT]; // [RQ17]
	assign CORRUPT_DOUBLE_O = cmd[BIT_CORRUPT_DBL]; // [RQ17]

	// thresholds and interrupt mask
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sthr <= THR_RST;
			dthr <= THR_RST;
			mask <= MASK_RST; // [RQ13]
		end else if (wr) begin
			if (idx == IDX_STHR) begin
				sthr <= (sthr & ~bmask) | wdat; // [RQ2]
			end
			if (idx == IDX_DTHR) begin
				dthr <= (dthr & ~bmask) | wdat; // [RQ2]
			end
			if (idx == IDX_MASK && SEL_I[0]) begin
				mask <= DAT_I[4:0]; // [RQ13]
			end
		end
	end

	// single and double error counters
	ecs_err_counter u_scount (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.inc_i(s_inc), // [RQ2]
		.clr_i(s_cnt_clr),
		.thr_i(sthr),
		.count_o(scount),
		.cross_o(s_cross)
	);

	ecs_err_counter u_dcount (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.inc_i(d_ev), // [RQ2]
		.clr_i(d_cnt_clr),
		.thr_i(dthr),
		.count_o(dcount),
		.cross_o(d_cross)
	);

	// error addresses: latest, or first when first mode is on
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			saddr <= 32'h00000000;
			s_have <= 1'b0;
		end else if (SERR_I && (clr_all || !(cmd[BIT_FIRST] && s_have))) begin
			saddr <= ERR_ADDR_I; // [RQ4] [RQ6]
			s_have <= 1'b1;
		end else if (clr_all) begin
			saddr <= 32'h00000000; // [RQ4]
			s_have <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			daddr <= 32'h00000000;
			d_have <= 1'b0;
		end else if (d_ev && (clr_all || !(cmd[BIT_FIRST] && d_have))) begin
			daddr <= ERR_ADDR_I; // [RQ5] [RQ6]
			d_have <= 1'b1;
		end else if (clr_all) begin
			daddr <= 32'h00000000; // [RQ5]
			d_have <= 1'b0;
		end
	end

	// fifo pops on reads; syndrome steps after the odd sub-word
	assign sdata_pop = rd && idx == IDX_SDATA;
	assign ddata_pop = rd && idx == IDX_DDATA;
	assign ssynd_pop = sdata_pop && sdata_level != '0 && sdata_ptr[0]; // [RQ10]

	ecs_capture_fifo #(.W(SUB_W), .DEPTH(SUB_DEPTH), .PW(DPW), .LW(DLW)) u_sdata (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.load_i(SERR_I), // [RQ7]
		.load_data_i(ERR_DATA_I),
		.pop_i(sdata_pop),
		.clr_i(clr_all), // [RQ8]
		.head_o(sdata_head),
		.ptr_o(sdata_ptr),
		.level_o(sdata_level)
	);

	ecs_capture_fifo #(.W(SYND_W), .DEPTH(PARTS), .PW(SPW), .LW(SLW)) u_ssynd (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.load_i(SERR_I), // [RQ9]
		.load_data_i(ERR_SYND_I),
		.pop_i(ssynd_pop),
		.clr_i(clr_all), // [RQ8]
		.head_o(ssynd_head),
		.ptr_o(ssynd_ptr),
		.level_o(ssynd_level)
	);

	ecs_capture_fifo #(.W(SUB_W), .DEPTH(SUB_DEPTH), .PW(DPW), .LW(DLW)) u_ddata (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.load_i(d_ev), // [RQ11]
		.load_data_i(ERR_DATA_I),
		.pop_i(ddata_pop),
		.clr_i(clr_all), // [RQ8]
		.head_o(ddata_head),
		.ptr_o(),
		.level_o()
	);

	// interrupt status sources and clears; a new event wins
	assign st_set[ST_SERR] = SERR_I;
	assign st_set[ST_DERR] = d_ev;
	assign st_set[ST_SMAX] = s_cross; // [RQ2]
	assign st_set[ST_DMAX] = d_cross; // [RQ2]
	assign st_set[ST_RMW] = RMW_DERR_I && d_ev;
	assign st_clr = ((wr && idx == IDX_STATUS && SEL_I[0]) ? DAT_I[4:0] : 5'h00)
		| {ST_W{clr_irq}}; // [RQ12] [RQ19]

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			status <= 5'h00;
		end else begin
			status <= (status & ~st_clr) | st_set; // [RQ12]
		end
	end

	// per-part error flags, write one clears, set wins
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sloc <= '0;
			dloc <= '0;
		end else begin
			sloc <= (sloc & ~((wr && idx == IDX_SLOC) ? wdat[PARTS-1:0] : '0))
				| (SERR_I ? ERR_PART_I : '0); // [RQ14]
			dloc <= (dloc & ~((wr && idx == IDX_DLOC) ? wdat[PARTS-1:0] : '0))
				| (d_ev ? ERR_PART_I : '0); // [RQ15]
		end
	end

	// unmasked pending status drives the interrupt
	assign IRQ_O = |(status & ~mask); // [RQ20]

	// read mux; unmapped and write-only words read zero
	always_comb begin
		rdata = 32'h00000000;
		case (idx)
			IDX_CMD: rdata = cmd;
			IDX_STHR: rdata = sthr;
			IDX_DTHR: rdata = dthr;
			IDX_SCNT: rdata = scount; // [RQ3]
			IDX_DCNT: rdata = dcount; // [RQ3]
			IDX_SADDR: rdata = saddr;
			IDX_DADDR: rdata = daddr;
			IDX_SDATA: rdata = sdata_head;
			IDX_SSYND: rdata = {{(32 - SYND_W){1'b0}}, ssynd_head}; // [RQ9]
			IDX_DDATA: rdata = ddata_head;
			IDX_STATUS: rdata = {{(32 - ST_W){1'b0}}, status};
			IDX_SLOC: rdata = {{(32 - PARTS){1'b0}}, sloc};
			IDX_DLOC: rdata = {{(32 - PARTS){1'b0}}, dloc};
			default: rdata = 32'h00000000;
		endcase
	end

	// read data captured on the request edge, held until next read
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DAT_O <= 32'h00000000;
		end else if (rd) begin
			DAT_O <= rdata;
		end
	end

	// checks on the register bank
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence s_reg_write(logic [5:0] i);
		wr && idx == i;
	endsequence
	sequence s_quiet;
		!SERR_I && !DERR_I;
	endsequence

	a_bus_ack: assert property (req |=> ack ##1 !ack)
		else $error("ack not a single pulse after request");

	a_single_count: assert property ( // [RQ2]
		s_inc && !s_cnt_clr && scount != 32'hffffffff |=> scount == $past(scount) + 32'h1)
		else $error("single error count did not step");

	a_clear_cmd: assert property ( // [RQ18]
		s_reg_write(IDX_CMD) ##0 wdat[BIT_CLR_ALL] ##0 s_quiet |=>
		scount == 32'h0 && saddr == 32'h0 && dcount == 32'h0 && sdata_level == '0)
		else $error("clear command left state behind");

	a_last_addr: assert property ( // [RQ4]
		SERR_I && !cmd[BIT_FIRST] |=> saddr == $past(ERR_ADDR_I))
		else $error("single error address not latest");
	a_first_hold: assert property ( // [RQ6]
		cmd[BIT_FIRST] && d_have && d_ev && !clr_all |=> daddr == $past(daddr))
		else $error("first double error address overwritten");
	a_data_low_first: assert property ( // [RQ7]
		SERR_I |=> sdata_level == DLW'(SUB_DEPTH) && sdata_head == $past(ERR_DATA_I[31:0]))
		else $error("single error data not loaded low first");

	a_synd_follows: assert property ( // [RQ10]
		sdata_level != '0 |-> ssynd_ptr == SPW'(sdata_ptr >> 1))
		else $error("syndrome part differs from data part");

	a_status_w1c: assert property ( // [RQ12]
		s_reg_write(IDX_STATUS) ##0 SEL_I[0] && DAT_I[ST_SERR] ##0 s_quiet |=> !status[ST_SERR])
		else $error("status bit not cleared by write one");

	a_cross_irq: assert property ( // [RQ20]
		s_cross && !mask[ST_SMAX] && !clr_irq |=> status[ST_SMAX] && IRQ_O)
		else $error("threshold crossing gave no interrupt");
	a_irq_clear: assert property ( // [RQ19]
		((clr_irq && !RMW_DERR_I) and s_quiet) |=> status == 5'h00 && !IRQ_O)
		else $error("interrupt clear command ineffective");
	a_loc_set: assert property ( // [RQ14]
		SERR_I |=> (sloc & $past(ERR_PART_I)) == $past(ERR_PART_I))
		else $error("single error part flag not set");
endmodule : ecs_ecc_regs
`default_nettype wire

//--- testbench/ecs_err_source.sv
// behavioural model of the ecc decoder that reports errors to the register bank
`default_nettype none
module ecs_err_source (
	input wire logic clk_i,
	output logic serr_o,
	output logic derr_o,
	output logic rmw_o,
	output logic [31:0] addr_o,
	output logic [ecs_pkg::DATA_W-1:0] data_o,
	output logic [ecs_pkg::PARTS*ecs_pkg::SYND_W-1:0] synd_o,
	output logic [ecs_pkg::PARTS-1:0] part_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import ecs_pkg::*;
	// quiet lines before the first report
	initial begin
		serr_o = 1'b0;
		derr_o = 1'b0;
		rmw_o = 1'b0;
		addr_o = '0;
		data_o = '0;
		synd_o = '0;
		part_o = '0;
	end
	// one-cycle report; lines are scrambled once it has been taken
	task automatic fire(input logic dbl, input logic rmw, input logic [31:0] addr,
		input logic [DATA_W-1:0] data, input logic [PARTS*SYND_W-1:0] synd,
		input logic [PARTS-1:0] part);
		@(posedge clk_i);
		serr_o <= !dbl;
		derr_o <= dbl;
		rmw_o <= rmw;
		addr_o <= addr;
		data_o <= data;
		synd_o <= synd;
		part_o <= part;
		@(posedge clk_i);
		serr_o <= 1'b0;
		derr_o <= 1'b0;
		rmw_o <= 1'b0;
		addr_o <= ~addr;
		data_o <= ~data;
		synd_o <= ~synd;
		part_o <= ~part;
	endtask : fire
endmodule : ecs_err_source
`default_nettype wire

//--- testbench/ecs_ecc_regs_test.sv
// self-checking bench for the ecc register bank
`default_nettype none
module ecs_ecc_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ecs_pkg::*;
	logic clk, rst_n, cyc, stb, we, ack, serr, derr, rmw, irq;
	logic [3:0] sel;
	logic [7:0] adr;
	logic [31:0] dat_w, dat_r, eaddr, a, t;
	logic [DATA_W-1:0] edata, d;
	logic [PARTS*SYND_W-1:0] esynd, s;
	logic [PARTS-1:0] epart;
	wire [4:0] ctl;
	logic [31:0] exp_q[$];
	integer seed = 32'h8f94341c;
	int fails = 0;
	int num_checks = 0;
	ecs_ecc_regs DUT (.MCLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.SEL_I(sel), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
		.SERR_I(serr), .DERR_I(derr), .RMW_DERR_I(rmw), .ERR_ADDR_I(eaddr),
		.ERR_DATA_I(edata), .ERR_SYND_I(esynd), .ERR_PART_I(epart),
		.COUNT_SERR_EN_O(ctl[4]), .CORRECT_EN_O(ctl[3]), .DETECT_DERR_EN_O(ctl[2]),
		.CORRUPT_EN_O(ctl[1]), .CORRUPT_DOUBLE_O(ctl[0]), .IRQ_O(irq));
	ecs_err_source src (.clk_i(clk), .serr_o(serr), .derr_o(derr), .rmw_o(rmw),
		.addr_o(eaddr), .data_o(edata), .synd_o(esynd), .part_o(epart));
	// clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic finish_test();
		if (fails == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one classic cycle; for a read, dv is noted as the expected data
	task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] dv);
		int n;
		n = 0;
		if (!w) begin
			exp_q.push_back(dv);
		end
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat_w <= w ? dv : $random(seed);
		sel <= 4'hf;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (n >= 40) begin
			fails++;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : bus
	// random error report from the decoder model
	task automatic ev(input logic dbl, input logic r, input logic [1:0] p);
		a = $random(seed);
		d = {$random(seed), $random(seed), $random(seed), $random(seed)};
		s = (PARTS * SYND_W)'($random(seed));
		src.fire(dbl, r, a, d, s, p);
		#1;
	endtask : ev
	// read monitor: oldest note against the data on the acked read
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			check(dat_r, exp_q.pop_front());
		end
	end
	initial begin
		#200000;
		fails++;
		finish_test();
	end
	initial begin
		{cyc, stb, we, sel, adr, dat_w} = '0;
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		check({27'h0, ctl}, 32'h1c);
		for (int i = 0; i < 15; i++) bus(0, i[5:0], i == 0 ? 32'hf : (i < 3 ? 1 : 0));
		for (int i = 1; i < 3; i++) begin
			t = $random(seed);
			bus(1, i[5:0], t);
			bus(0, i[5:0], t);
			bus(1, i[5:0], 32'h1);
		end
		bus(1, 3, $random(seed));
		bus(0, 3, 0);
		bus(1, 6'h20, $random(seed));
		bus(0, 6'h20, 0);
		bus(1, 0, 32'h300);
		bus(0, 0, 32'h300);
		check({27'h0, ctl}, 32'h03);
		// default mask hides a single error; then clear its traces
		ev(0, 0, 2'b01);
		check({31'h0, irq}, 0);
		bus(1, 0, 32'h1f);
		bus(1, 10, 1);
		bus(1, 12, 1);
		bus(1, 11, 0);
		bus(0, 11, 0);
		// two single errors: count crosses the threshold of one
		ev(0, 0, 2'b01);
		check({31'h0, irq}, 1);
		ev(0, 0, 2'b10);
		bus(0, 3, 2);
		bus(0, 5, a);
		bus(0, 10, 5);
		bus(0, 12, 3);
		for (int i = 0; i < 4; i++) begin
			if (i % 2 == 0) bus(0, 8, {24'h0, s[4*i+:8]});
			bus(0, 7, d[32*i+:32]);
		end
		bus(0, 7, 0);
		bus(1, 10, 1);
		bus(0, 10, 4);
		bus(1, 12, 1);
		bus(0, 12, 2);
		bus(1, 0, 32'h80f);
		bus(0, 10, 0);
		check({31'h0, irq}, 0);
		bus(0, 0, 32'hf);
		// double error during read-modify-write
		ev(1, 1, 2'b10);
		check({31'h0, irq}, 1);
		bus(0, 4, 1);
		bus(0, 6, a);
		bus(0, 10, 32'h12);
		bus(0, 13, 2);
		for (int i = 0; i < 4; i++) bus(0, 9, d[32*i+:32]);
		bus(1, 11, 32'h1f);
		check({31'h0, irq}, 0);
		// counting and detection switched off
		t = a;
		bus(1, 0, 32'ha);
		ev(1, 0, 2'b01);
		ev(0, 0, 2'b01);
		bus(0, 4, 1);
		bus(0, 3, 2);
		bus(0, 5, a);
		bus(0, 6, t);
		// clear, then keep the first address
		bus(1, 0, 32'h415);
		bus(0, 3, 0);
		bus(0, 6, 0);
		bus(0, 9, 0);
		ev(0, 0, 2'b01);
		t = a;
		ev(0, 0, 2'b01);
		bus(0, 5, t);
		// counters clear when read
		bus(1, 0, 32'h485);
		bus(0, 3, 2);
		bus(0, 3, 0);
		// two double errors: crossing, first address, clear on read
		ev(1, 0, 2'b01);
		t = a;
		ev(1, 0, 2'b01);
		bus(0, 6, t);
		bus(0, 10, 32'h1f);
		bus(0, 4, 2);
		bus(0, 4, 0);
		finish_test();
	end
endmodule : ecs_ecc_regs_test
`default_nettype wire
